/* verilog/llld_cfg.svh */
// Constants for the line-lock loss detector: offsets, fields, counts.
// Assumes inclusion by bare name from the package and the top module.
`ifndef LLLD_CFG_SVH
`define LLLD_CFG_SVH
`define LLLD_ADDR_CTRL 8'h19
`define LLLD_ADDR_SPARE 8'h1A
`define LLLD_ADDR_ID 8'h1B
`define LLLD_CTRL_SEL_BIT 5
`define LLLD_CTRL_RESET 8'h00
`define LLLD_SEL_RESET 1'b0
`define LLLD_MISS_LIMIT_MULTI 4'hC
`define LLLD_MISS_LIMIT_SINGLE 4'h1
`define LLLD_WHITE_PEAK_CODE 8'hF8
`define LLLD_FULL_SCALE_CODE 8'hFF
`define LLLD_LINE_WINDOW 12'hFA0
`define LLLD_LOCK_LINES 4'h4
`endif

/* verilog/llld_pkg.sv */
// Types shared by the line-lock loss detector modules.
// Assumes llld_cfg.svh is on the include path.
`include "llld_cfg.svh"
package llld_pkg;
  typedef enum logic [1:0] {LLLD_ACQUIRE, LLLD_TRACK} llld_state_t;
endpackage : llld_pkg

/* verilog/llld_sync2.sv */
// Two-flop synchroniser for inputs arriving from outside the clock domain.
// Assumes CLOCK is the master clock and the output is read by one domain.
`timescale 1ns/1ps
module llld_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : llld_sync2

/* verilog/llld_top.sv */
// Line-lock loss detector with its registers at 0x19-0x1B and white peak.
// Assumes an upstream serial decoder gives one-cycle register strobes and
// that the horizontal sync and peak enable come from outside the clock.
`timescale 1ns/1ps
`include "llld_cfg.svh"

module llld_top #(
  parameter logic [7:0] PART_CODE = 8'h5A, // Value arbitrary
  parameter logic [11:0] LINE_WINDOW = `LLLD_LINE_WINDOW,
  parameter logic [3:0] LOCK_LINES = `LLLD_LOCK_LINES
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // Register access
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Video sync and conversion
  input wire logic HSYNC_IN,
  input wire logic WHITE_PEAK_LIMIT_EN,
  input wire logic [7:0] VIDEO_CODE,
  output logic GAIN_REDUCE,
  output logic [7:0] VIDEO_OUT,
  // Status
  output logic LINE_LOCKED,
  output logic LOCK_LOST
);
  logic [1:0] sync_bits;
  logic hsync_s, hsync_prev_reg, hsync_edge;
  logic peak_en;
  logic sync_loss_threshold_sel_reg;
  llld_pkg::llld_state_t state_reg;
  logic [11:0] line_cnt_reg;
  logic [3:0] miss_cnt_reg, miss_cnt_next, good_cnt_reg;
  logic [3:0] miss_limit;
  logic window_end, lose_now;

  // One clock domain, so every assertion shares these
  default clocking cb_llld @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  // HSYNC_IN and WHITE_PEAK_LIMIT_EN are synchronised before any logic reads them
  llld_sync2 #(.WIDTH(2)) u_sync (
    .clock(CLOCK),
    .resetn(RESETN),
    .async_in({WHITE_PEAK_LIMIT_EN, HSYNC_IN}),
    .sync_out(sync_bits)
  );
  assign hsync_s = sync_bits[0];
  assign peak_en = sync_bits[1];

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      hsync_prev_reg <= 1'b0;
    end else begin
      hsync_prev_reg <= hsync_s;
    end
  end
  assign hsync_edge = hsync_s & ~hsync_prev_reg;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      sync_loss_threshold_sel_reg <= `LLLD_SEL_RESET;
    end else if (REG_WR && REG_ADDR == `LLLD_ADDR_CTRL) begin
      sync_loss_threshold_sel_reg <= REG_WDATA[`LLLD_CTRL_SEL_BIT];
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        `LLLD_ADDR_CTRL: begin
          REG_RDATA <= 8'(sync_loss_threshold_sel_reg) << `LLLD_CTRL_SEL_BIT;
        end
        `LLLD_ADDR_ID: REG_RDATA <= PART_CODE;
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end

  // Line window timer restarts on every sync so a late sync is a miss
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      line_cnt_reg <= 12'h000;
    end else if (hsync_edge || window_end) begin
      line_cnt_reg <= 12'h000;
    end else begin
      line_cnt_reg <= line_cnt_reg + 12'h001;
    end
  end
  assign window_end = (line_cnt_reg == LINE_WINDOW - 12'h001) && !hsync_edge;

  assign miss_limit = sync_loss_threshold_sel_reg ?
    `LLLD_MISS_LIMIT_SINGLE : `LLLD_MISS_LIMIT_MULTI;

  always_comb begin
    miss_cnt_next = miss_cnt_reg;
    if (hsync_edge) begin
      miss_cnt_next = 4'h0;
    end else if (window_end) begin
      miss_cnt_next = miss_cnt_reg + 4'h1;
    end
  end
  assign lose_now = (state_reg == llld_pkg::LLLD_TRACK) && window_end &&
    (miss_cnt_next >= miss_limit);

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      miss_cnt_reg <= 4'h0;
    end else if (lose_now || state_reg == llld_pkg::LLLD_ACQUIRE) begin
      miss_cnt_reg <= 4'h0;
    end else begin
      miss_cnt_reg <= miss_cnt_next;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= llld_pkg::LLLD_ACQUIRE;
      good_cnt_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        llld_pkg::LLLD_ACQUIRE: begin
          if (window_end) begin
            good_cnt_reg <= 4'h0;
          end else if (hsync_edge) begin
            if (good_cnt_reg + 4'h1 >= LOCK_LINES) begin
              state_reg <= llld_pkg::LLLD_TRACK;
              good_cnt_reg <= 4'h0;
            end else begin
              good_cnt_reg <= good_cnt_reg + 4'h1;
            end
          end
        end
        llld_pkg::LLLD_TRACK: begin
          if (lose_now) begin
            state_reg <= llld_pkg::LLLD_ACQUIRE;
          end
        end
        // Unused codes fall back to a fresh search
        default: begin
          state_reg <= llld_pkg::LLLD_ACQUIRE;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      LINE_LOCKED <= 1'b0;
      LOCK_LOST <= 1'b0;
    end else begin
      LINE_LOCKED <= (state_reg == llld_pkg::LLLD_TRACK) && !lose_now;
      LOCK_LOST <= lose_now;
    end
  end

  // white peak limit
  // Full scale already saturates in the converter, so only flag the gain
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      GAIN_REDUCE <= 1'b0;
      VIDEO_OUT <= 8'h00;
    end else begin
      GAIN_REDUCE <= peak_en && (VIDEO_CODE > `LLLD_WHITE_PEAK_CODE);
      VIDEO_OUT <= VIDEO_CODE;
    end
  end

  // Assertions
  a_single_miss_drop: assert property (
    (state_reg == llld_pkg::LLLD_TRACK && sync_loss_threshold_sel_reg &&
     window_end) |=> state_reg == llld_pkg::LLLD_ACQUIRE)
    else $error("single miss did not drop lock");
  a_multi_miss_hold: assert property (
    (state_reg == llld_pkg::LLLD_TRACK && !sync_loss_threshold_sel_reg &&
     window_end && miss_cnt_reg < `LLLD_MISS_LIMIT_MULTI - 4'h1) |=>
    state_reg == llld_pkg::LLLD_TRACK)
    else $error("lock dropped before twelve misses");
  a_twelfth_miss_drop: assert property (
    (state_reg == llld_pkg::LLLD_TRACK && !sync_loss_threshold_sel_reg &&
     window_end && miss_cnt_reg == `LLLD_MISS_LIMIT_MULTI - 4'h1) |=>
    state_reg == llld_pkg::LLLD_ACQUIRE)
    else $error("twelfth miss did not drop lock");
  a_lost_flag: assert property (
    LOCK_LOST |-> state_reg == llld_pkg::LLLD_ACQUIRE && !LINE_LOCKED)
    else $error("loss did not return to acquisition");
  a_miss_clear: assert property (
    hsync_edge |=> miss_cnt_reg == 4'h0)
    else $error("miss count not cleared by sync");
  a_sel_write: assert property (
    (REG_WR && REG_ADDR == `LLLD_ADDR_CTRL) |=>
    sync_loss_threshold_sel_reg == $past(REG_WDATA[`LLLD_CTRL_SEL_BIT]))
    else $error("select bit not written");
  a_ctrl_reserved: assert property (
    (REG_RD && REG_ADDR != `LLLD_ADDR_ID) |=> (REG_RDATA & 8'hDF) == 8'h00)
    else $error("reserved bits read nonzero");
  a_id_read: assert property (
    (REG_RD && REG_ADDR == `LLLD_ADDR_ID) |=> REG_RDATA == PART_CODE)
    else $error("part code wrong");
  a_peak_gain: assert property (
    GAIN_REDUCE == ($past(VIDEO_CODE) > `LLLD_WHITE_PEAK_CODE &&
    $past(peak_en)))
    else $error("gain flag does not follow peak");
  a_locked_track: assert property (
    LINE_LOCKED == ($past(state_reg) == llld_pkg::LLLD_TRACK &&
    !$past(lose_now)))
    else $error("locked flag does not follow tracking");
endmodule : llld_top

/* tb/llld_video_src.sv */
// Video source model: sync pulses at a fixed spacing.
// Assumes the bench gives the clock and the run level.
`timescale 1ns/1ps
module llld_video_src (
  // Clock and control
  input wire logic clock,
  input wire logic run,
  input wire logic [7:0] period,
  // Sync out
  output logic hsync
);
  logic [7:0] cnt_reg = 8'h00;
  initial hsync = 1'b0;
  // Two cycles wide so the input stage cannot miss it
  always @(posedge clock) begin
    cnt_reg <= (!run || cnt_reg == period - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
    hsync <= run && (cnt_reg < 8'h02);
  end
endmodule : llld_video_src

/* tb/line_lock_loss_detect_tb_top.sv */
// Bench for the line-lock loss detector, with a reference model.
// Assumes a short line window so loss counts stay brief.
`timescale 1ns/1ps
module line_lock_loss_detect_tb_top;
  localparam logic [7:0] PART = 8'h3C; // Value arbitrary
  logic clock, resetn, wr, rd, hs, pk, run, gain, lkd, lost;
  logic [7:0] addr, wd, rdat, code, vout;
  int n_mismatch, cmp_count, seed, sel, n, cycles = 0;
  logic [7:0] q[$];
  logic [7:0] al[4] = '{8'h19, 8'h1A, 8'h1B, 8'h1C};

  llld_top #(.PART_CODE(PART), .LINE_WINDOW(12'h014), .LOCK_LINES(4'h4))
    DUT (.CLOCK(clock), .RESETN(resetn), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wd), .REG_RDATA(rdat), .HSYNC_IN(hs),
    .WHITE_PEAK_LIMIT_EN(pk), .VIDEO_CODE(code), .GAIN_REDUCE(gain),
    .VIDEO_OUT(vout), .LINE_LOCKED(lkd), .LOCK_LOST(lost));
  llld_video_src SRC (.clock(clock), .run(run), .period(8'h0A), .hsync(hs));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input string s, input logic [7:0] v,
    input logic [7:0] e);
    cmp_count++;
    if (v !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, e, v);
    end
  endtask : check

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  function automatic logic [7:0] model(input logic [7:0] a);
    if (a == 8'h19) return sel ? 8'h20 : 8'h00;
    if (a == 8'h1B) return PART;
    return 8'h00;
  endfunction : model

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clock);
    wr <= 1'b0;
    if (a == 8'h19) sel = d[5];
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    check("rdata", rdat, model(a));
  endtask : reg_rd

  // Lock on, stop syncs, count cycles to the loss pulse
  task automatic lose(input int lo, input int hi);
    @(posedge clock);
    run <= 1'b1;
    for (n = 0; lkd !== 1'b1 && n < 300; n++) @(negedge clock);
    check("locked", lkd, 1'b1);
    repeat (30) @(posedge clock);
    run <= 1'b0;
    for (n = 0; lost !== 1'b1 && n < 400; n++) @(negedge clock);
    check("loss time", n >= lo && n <= hi, 1'b1);
    check("to acquire", lkd, 1'b0);
  endtask : lose

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    seed = 32'hefb10a2d;
    {n_mismatch, cmp_count, sel} = '0;
    {resetn, wr, rd, pk, run} = '0;
    {addr, wd, code} = '0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    foreach (al[i]) reg_rd(al[i]);
    foreach (al[i]) reg_wr(al[i], 8'hFF);
    foreach (al[i]) reg_rd(al[i]);
    $display("register test done");
    lose(8, 32);
    reg_wr(8'h19, 8'hDF);
    reg_rd(8'h19);
    lose(228, 252);
    $display("loss test done");
    for (int i = 0; i < 96; i++) begin
      @(posedge clock);
      if (i % 24 == 0) pk <= ~pk;
      code <= i % 4 == 0 ? 8'hF8 : i % 4 == 1 ? 8'hF9 : 8'($random(seed));
      @(negedge clock);
      if (q.size() > 0 && i % 24 > 4)
        check("gain", gain, q[0] > 8'hF8 && pk);
      if (q.size() > 0)
        check("video", vout, q.pop_front());
      q.push_back(code);
    end
    $display("peak test done");
    reg_wr(8'h19, 8'h20);
    lose(8, 32);
    @(posedge clock);
    run <= 1'b1;
    repeat (120) @(posedge clock);
    resetn <= 1'b0;
    @(negedge clock);
    check("locked in reset", lkd, 1'b0);
    sel = 0;
    @(posedge clock);
    resetn <= 1'b1;
    run <= 1'b0;
    reg_rd(8'h19);
    $display("reset test done");
    report_and_stop();
  end
endmodule : line_lock_loss_detect_tb_top
